// *** saei_pkg.sv ***
/*
  constants, states and timing figures for the servo amplifier engage interlock.
  assumes a single 20 MHz clock shared by every file that imports it.

*/
`default_nettype none
package saei_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_HZ         = 20_000_000; // system clock rate
  localparam int unsigned ENABLE_WAIT_MS = 100;        // ready must be valid by then
  localparam int unsigned SETTLE_MS      = 1000;       // settling after ready
  localparam int unsigned CONTACT_MS     = 3000;       // window for power applied
  localparam int unsigned ZERO_HOLD_MS   = 200;        // demands held at zero
  // all times round down (whole cycles per ms); exact at 20 MHz
  localparam int unsigned ENABLE_WAIT_CYC = (CLK_HZ / 1000) * ENABLE_WAIT_MS;
  localparam int unsigned SETTLE_CYC      = (CLK_HZ / 1000) * SETTLE_MS;
  localparam int unsigned CONTACT_CYC     = (CLK_HZ / 1000) * CONTACT_MS;
  localparam int unsigned ZERO_HOLD_CYC   = (CLK_HZ / 1000) * ZERO_HOLD_MS;
  localparam int unsigned TIMER_W         = 32;        // timer width

  // ****************************************************************
  // sequence states
  // ****************************************************************
  typedef enum logic [2:0] {
    SAEI_IDLE    = 3'h0, // nothing engaged
    SAEI_ENABLE  = 3'h1, // amp enable on, awaiting ready
    SAEI_SETTLE  = 3'h2, // ready seen, settling
    SAEI_CONTACT = 3'h3, // contactor on, awaiting power applied
    SAEI_HOLD    = 3'h4, // powered, demands still zero
    SAEI_RUN     = 3'h5  // servo control released
  } saei_state_t;

endpackage
`default_nettype wire

// *** saei_sync.sv ***
/*
  two-flop synchroniser for one level input.
  assumes the input is asynchronous to clk; preset value chosen by parameter.
*/
`timescale 1ns/1ps
`default_nettype none
module saei_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_q; // first stage, read only by second stage

  // ****************************************************************
  // two stages
  // ****************************************************************
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      meta_q   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

// *** saei_interlock.sv ***
/*
  engage sequencer: amp enable, settle, contactor, zero hold, run.
  assumes pin inputs are asynchronous; outputs drive external pin buffers.
*/
`timescale 1ns/1ps
`default_nettype none
module saei_interlock
  import saei_pkg::*;
#(
  parameter int unsigned ENABLE_CYC = ENABLE_WAIT_CYC,
  parameter int unsigned SETTLE_N   = SETTLE_CYC,
  parameter int unsigned CONTACT_N  = CONTACT_CYC,
  parameter int unsigned HOLD_N     = ZERO_HOLD_CYC
) (
  input  wire logic clk,             // 20 MHz
  input  wire logic reset,           // async, active high
  input  wire logic engage_req,      // level request to engage, same clock
  input  wire logic halt_sense_pin,  // high or open = emergency stop active
  input  wire logic amps_ready_n_pin,// low = amplifiers on and ready
  input  wire logic power_ok_n_pin,  // low = contactor operated
  output logic      contactor_n,     // contactor command, active low
  output logic      contactor,       // contactor command, active high
  output logic      amp_enable_n,    // enable request, active low
  output logic      amp_enable,      // enable request, active high
  output logic      demand_zero,     // high forces motor demands to zero
  output logic      servo_run,       // servo control released
  output logic      engage_fail      // one-cycle pulse when the enable or contactor window runs out with no ready or power applied
);

  // ****************************************************************
  // synchronised inputs
  // ****************************************************************
  logic        halt_s;       // synchronised halt sense
  logic        ready_n_s;    // synchronised ready, low true
  logic        power_n_s;    // synchronised power applied, low true
  saei_state_t state_q;      // sequence state
  logic [TIMER_W-1:0] tmr_q; // cycles spent in current state; held at zero in run
  logic        halt_act;     // emergency stop active
  logic        en_cmd;       // logical enable request
  logic        ct_cmd;       // logical contactor command

  // this unit's own halt input only; preset active
  saei_sync #(.RESET_VAL(1'b1)) u_halt (
    .clk      (clk),
    .reset    (reset),
    .async_in (halt_sense_pin),
    .sync_out (halt_s)
  );

  saei_sync #(.RESET_VAL(1'b1)) u_ready (
    .clk      (clk),
    .reset    (reset),
    .async_in (amps_ready_n_pin),
    .sync_out (ready_n_s)
  );

  saei_sync #(.RESET_VAL(1'b1)) u_power (
    .clk      (clk),
    .reset    (reset),
    .async_in (power_ok_n_pin),
    .sync_out (power_n_s)
  );

  // ****************************************************************
  // decode
  // ****************************************************************
  // only a low input releases the stop; high or open trips it
  assign halt_act = halt_s;

  function automatic logic enable_on(input saei_state_t s);
    enable_on = (s != SAEI_IDLE);
  endfunction

  function automatic logic contact_on(input saei_state_t s);
    contact_on = (s == SAEI_CONTACT) || (s == SAEI_HOLD) || (s == SAEI_RUN);
  endfunction

  assign en_cmd = enable_on(state_q);
  assign ct_cmd = contact_on(state_q);

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= SAEI_IDLE;
      tmr_q   <= '0;
    end
    else if (halt_act || !engage_req)
    begin
      state_q <= SAEI_IDLE; // withdraw everything, refuse engage
      tmr_q   <= '0;
    end
    else
    begin
      tmr_q <= tmr_q + TIMER_W'(1);
      unique case (state_q)
        SAEI_IDLE:
        begin
          state_q <= SAEI_ENABLE; // demands zero, request amps
          tmr_q   <= '0;
        end
        SAEI_ENABLE:
        begin
          // request held the full window, then ready checked
          if (tmr_q == TIMER_W'(ENABLE_CYC - 1))
          begin
            state_q <= ready_n_s ? SAEI_IDLE : SAEI_SETTLE;
            tmr_q   <= '0;
          end
        end
        SAEI_SETTLE:
        begin
          if (ready_n_s)
          begin
            state_q <= SAEI_IDLE; // ready lost while settling
            tmr_q   <= '0;
          end
          else if (tmr_q == TIMER_W'(SETTLE_N - 1))
          begin
            state_q <= SAEI_CONTACT;
            tmr_q   <= '0;
          end
        end
        SAEI_CONTACT:
        begin
          if (!power_n_s)
          begin
            state_q <= SAEI_HOLD; // confirmed in time
            tmr_q   <= '0;
          end
          else if (tmr_q == TIMER_W'(CONTACT_N - 1))
          begin
            state_q <= SAEI_IDLE; // drop contactor and enable
            tmr_q   <= '0;
          end
        end
        SAEI_HOLD:
        begin
          if (tmr_q == TIMER_W'(HOLD_N - 1))
          begin
            state_q <= SAEI_RUN;
            tmr_q   <= '0;
          end
        end
        SAEI_RUN:
        begin
          tmr_q <= '0;
        end
        default:
        begin
          state_q <= SAEI_IDLE;
          tmr_q   <= '0;
        end
      endcase
    end
  end

  // ****************************************************************
  // abandon pulse
  // ****************************************************************
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      engage_fail <= 1'b0;
    else
      engage_fail <= !halt_act && engage_req &&
                     (((state_q == SAEI_ENABLE) && ready_n_s && (tmr_q == TIMER_W'(ENABLE_CYC - 1))) ||
                      ((state_q == SAEI_CONTACT) && power_n_s && (tmr_q == TIMER_W'(CONTACT_N - 1))));
  end

  // ****************************************************************
  // output registers
  // ****************************************************************
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      contactor    <= 1'b0;
      contactor_n  <= 1'b1;
      amp_enable   <= 1'b0;
      amp_enable_n <= 1'b1;
      demand_zero  <= 1'b1;
      servo_run    <= 1'b0;
    end
    else
    begin
      contactor    <= ct_cmd;
      contactor_n  <= !ct_cmd;
      amp_enable   <= en_cmd;
      amp_enable_n <= !en_cmd;
      demand_zero  <= (state_q != SAEI_RUN);
      servo_run    <= (state_q == SAEI_RUN);
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_ct_pair;
    @(posedge clk) disable iff (reset) contactor_n == !contactor;
  endproperty
  a_ct_pair: assert property (p_ct_pair) else $error("contactor pair disagrees");

  property p_en_pair;
    @(posedge clk) disable iff (reset) amp_enable_n == !amp_enable;
  endproperty
  a_en_pair: assert property (p_en_pair) else $error("enable pair disagrees");

  property p_halt_drop;
    @(posedge clk) disable iff (reset) halt_s |-> ##2 (!amp_enable && !contactor && demand_zero);
  endproperty
  a_halt_drop: assert property (p_halt_drop) else $error("halt did not withdraw");

  property p_no_enable;
    @(posedge clk) disable iff (reset) (halt_s && $past(halt_s)) |-> ##1 !amp_enable;
  endproperty
  a_no_enable: assert property (p_no_enable) else $error("enable under halt");

  property p_ct_needs_en;
    @(posedge clk) disable iff (reset) contactor |-> amp_enable;
  endproperty
  a_ct_needs_en: assert property (p_ct_needs_en) else $error("contactor without enable");

  property p_run_zero;
    @(posedge clk) disable iff (reset) servo_run |-> !demand_zero && contactor;
  endproperty
  a_run_zero: assert property (p_run_zero) else $error("run without contactor");

  property p_enter_hold;
    @(posedge clk) disable iff (reset)
      (state_q == SAEI_CONTACT && !power_n_s && !halt_act && engage_req) |=> state_q == SAEI_HOLD;
  endproperty
  a_enter_hold: assert property (p_enter_hold) else $error("confirmation ignored");

  property p_settle_from_enable;
    @(posedge clk) disable iff (reset)
      $rose(state_q == SAEI_SETTLE) |-> $past(state_q) == SAEI_ENABLE && !$past(ready_n_s);
  endproperty
  a_settle_from_enable: assert property (p_settle_from_enable) else $error("settle without ready");

  property p_idle_off;
    @(posedge clk) disable iff (reset) (state_q == SAEI_IDLE) |=> !contactor && !amp_enable;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("idle drives commands");

  // contactor window ran out with no power applied and the request still standing
  sequence s_ct_timeout;
    (state_q == SAEI_CONTACT) && power_n_s && !halt_act && engage_req && (tmr_q == TIMER_W'(CONTACT_N - 1));
  endsequence

  // fail pulse next cycle, then both commands withdrawn
  sequence s_ct_withdraw;
    engage_fail ##1 (!contactor && !amp_enable);
  endsequence

  property p_ct_timeout_drop;
    @(posedge clk) disable iff (reset) s_ct_timeout |=> s_ct_withdraw;
  endproperty
  a_ct_timeout_drop: assert property (p_ct_timeout_drop) else $error("timeout kept commands");

endmodule
`default_nettype wire

// *** saei_amp_model.sv ***
/*
  partner model: servo amplifier and motor contactor on the far side.
  assumes its outputs reach the interlock through the interlock's synchronisers.
*/
`timescale 1ns/1ps
`default_nettype none
module saei_amp_model (
  input  wire logic       clk,
  input  wire logic       amp_enable,       // enable request seen
  input  wire logic       contactor,        // contactor command seen
  input  wire logic       amps_good,        // amplifiers healthy
  input  wire logic       coil_good,        // contactor able to operate
  input  wire logic [7:0] lag,              // answer delay in cycles
  output logic            amps_ready_n_pin, // low = amps on and ready
  output logic            power_ok_n_pin    // low = contactor operated
);
  logic [7:0] en_cnt_q; // cycles since enable
  logic [7:0] co_cnt_q; // cycles since contactor

  // ****************************************************************
  // answer delay counters
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    en_cnt_q <= !amp_enable ? 8'h00 : (en_cnt_q == 8'hFF) ? en_cnt_q : en_cnt_q + 8'h01;
    co_cnt_q <= !contactor ? 8'h00 : (co_cnt_q == 8'hFF) ? co_cnt_q : co_cnt_q + 8'h01;
  end

  // released pins rise to the pull-up level
  assign amps_ready_n_pin = !(amp_enable && amps_good && en_cnt_q >= lag);
  assign power_ok_n_pin   = !(contactor && coil_good && co_cnt_q >= lag);
endmodule
`default_nettype wire

// *** servo_amp_engage_interlock_tb.sv ***
/*
  self-checking bench for the engage interlock, with shortened timings.
  assumes the partner model and a second unit whose halt input is open.
*/
`timescale 1ns/1ps
`default_nettype none
module servo_amp_engage_interlock_tb;
  localparam int EN = 20; // enable window
  localparam int ST = 40; // settling
  localparam int CO = 60; // contactor window
  localparam int HO = 10; // zero hold
  logic clk = 1'b0, reset = 1'b1, engage_req = 1'b0, halt = 1'b1;
  logic amps_good = 1'b1, coil_good = 1'b1, rdy_n, pwr_n, amp_enable_b;
  logic contactor_n, contactor, amp_enable_n, amp_enable, demand_zero, servo_run, engage_fail;
  logic [7:0] lag = 8'h00;
  int err_count = 0, comparisons = 0, n1, n2;

  always #25 clk = ~clk;

  saei_interlock #(.ENABLE_CYC(EN), .SETTLE_N(ST), .CONTACT_N(CO), .HOLD_N(HO)) i_dut (
    .clk(clk), .reset(reset), .engage_req(engage_req), .halt_sense_pin(halt),
    .amps_ready_n_pin(rdy_n), .power_ok_n_pin(pwr_n), .contactor_n(contactor_n),
    .contactor(contactor), .amp_enable_n(amp_enable_n), .amp_enable(amp_enable),
    .demand_zero(demand_zero), .servo_run(servo_run), .engage_fail(engage_fail));
  // second unit, halt input left open
  saei_interlock #(.ENABLE_CYC(EN), .SETTLE_N(ST), .CONTACT_N(CO), .HOLD_N(HO)) i_dut_b (
    .clk(clk), .reset(reset), .engage_req(engage_req), .halt_sense_pin(1'b1),
    .amps_ready_n_pin(1'b1), .power_ok_n_pin(1'b1), .contactor_n(), .contactor(),
    .amp_enable_n(), .amp_enable(amp_enable_b), .demand_zero(), .servo_run(), .engage_fail());
  saei_amp_model i_amp (.clk(clk), .amp_enable(amp_enable), .contactor(contactor),
    .amps_good(amps_good), .coil_good(coil_good), .lag(lag),
    .amps_ready_n_pin(rdy_n), .power_ok_n_pin(pwr_n));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input string name, input logic exp, input logic got);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return amp_enable;
      1: return contactor;
      2: return servo_run;
      default: return engage_fail;
    endcase
  endfunction

  // bounded wait for an output to go high
  task automatic wait_hi(input int sel, input int bound, output int n);
    n = 0;
    while (pick(sel) !== 1'b1 && n < bound)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= bound)
    begin
      err_count++;
      $display("mismatch wait_%0d expected 1 seen timeout", sel);
      report_and_stop();
    end
  endtask

  // both polarities checked every cycle
  always @(negedge clk)
  begin
    chk("contactor_n", ~contactor, contactor_n);
    chk("amp_enable_n", ~amp_enable, amp_enable_n);
  end

  task automatic idle();
    engage_req = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    repeat (5) @(negedge clk);
    chk("rst_contactor", 1'b0, contactor);
    chk("rst_amp_enable", 1'b0, amp_enable);
    chk("rst_servo_run", 1'b0, servo_run);
    reset = 1'b0;
    $display("test reset done");
  endtask

  task automatic t_engage();
    halt = 1'b0;
    lag = 8'h05;
    engage_req = 1'b1;
    wait_hi(0, 10, n1);
    wait_hi(1, 200, n1);
    chk("settle_gap", 1'b1, n1 >= EN + ST);
    chk("zero_at_contact", 1'b1, demand_zero);
    wait_hi(2, 200, n2);
    chk("hold_gap", 1'b1, n2 >= HO);
    @(negedge clk);
    chk("demand_released", 1'b0, demand_zero);
    chk("unit_b_enable", 1'b0, amp_enable_b);
    $display("test engage done");
  endtask

  task automatic t_halt();
    halt = 1'b1;
    repeat (4) @(negedge clk);
    chk("halt_contactor", 1'b0, contactor);
    chk("halt_amp_enable", 1'b0, amp_enable);
    chk("halt_demand_zero", 1'b1, demand_zero);
    chk("halt_servo_run", 1'b0, servo_run);
    repeat (50) @(negedge clk);
    chk("halt_hold_off", 1'b0, amp_enable);
    idle();
    halt = 1'b0;
    $display("test halt done");
  endtask

  task automatic t_no_ready();
    amps_good = 1'b0;
    engage_req = 1'b1;
    wait_hi(3, EN + 20, n1);
    chk("no_ready_contactor", 1'b0, contactor);
    chk("no_ready_held", 1'b1, amp_enable);
    // request still high here, so only the abandon can clear the enable
    @(negedge clk);
    chk("no_ready_drop", 1'b0, amp_enable);
    idle();
    amps_good = 1'b1;
    $display("test no ready done");
  endtask

  task automatic t_no_power();
    coil_good = 1'b0;
    engage_req = 1'b1;
    wait_hi(1, 200, n1);
    wait_hi(3, CO + 10, n2);
    // fail pulse comes one cycle before the outputs fall: contactor stood n2 + 1 cycles
    chk("window_length", 1'b1, n2 + 1 >= CO);
    chk("nopwr_held", 1'b1, contactor);
    // request still high, so the drop comes from the timeout alone
    @(negedge clk);
    chk("nopwr_contactor", 1'b0, contactor);
    chk("nopwr_amp_enable", 1'b0, amp_enable);
    idle();
    coil_good = 1'b1;
    $display("test no power done");
  endtask

  initial
  begin
    t_reset();
    t_engage();
    t_halt();
    t_no_ready();
    t_no_power();
    report_and_stop();
  end
endmodule
`default_nettype wire
